/* File: hw/ssp_top.sv */
// APB register file and pin control for the serial and SPI ports
//
// Summary of operation
// - A serial port direction bit of 0 makes its pin an input, 1 an output, absent an override.
// - An enabled transmit channel forces its pin to output, receive to input, ignoring the bit.
// - When the serial channel is disabled the direction bit again sets that pin's direction.
// - After a direction write, data and input reads show the right value within three cycles.
// - Reduced-drive bit 0 gives full drive, 1 about a third, and is ignored for inputs.
// - Pull-enable turns on the pull for inputs and, at polarity 0 only, open-drain outputs, not push-pull outputs.
// - Out of reset the serial pins have pulls enabled with pull-up polarity.
// - Polarity 0 is pull-up for inputs and open drain, 1 is pull-down for inputs only.
// - Wired-or bit 1 drives low only and leaves high undriven, 0 is push-pull, inputs unaffected.
// - SPI port data reads give the latch for output pins and the sampled level otherwise.
// - The SPI peripheral sets direction and function of SPI port pins 5 to 2 itself.
// - The SPI port input register always returns sampled pin levels, outputs too.
// - Writes to the input registers are ignored and change nothing.
// - Serial port data reads give the latch for output pins and the pin level for inputs.
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_top (
	input wire logic clock,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SSP_ADDR_W-1:0] paddr,
	input wire logic [`SSP_DATA_W-1:0] pwdata,
	output logic [`SSP_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sci_tx_en,
	input wire logic sci_rx_en,
	input wire logic sci_txd,
	input wire logic spi_en,
	input wire logic [`SSP_SPI_OVR_W-1:0] spi_dir,
	input wire logic [`SSP_SPI_OVR_W-1:0] spi_out,
	input wire logic [`SSP_SER_W-1:0] serial_port_pins_in,
	output logic [`SSP_SER_W-1:0] serial_port_pins_out,
	output logic [`SSP_SER_W-1:0] serial_port_pins_oe,
	output logic [`SSP_SER_W-1:0] serial_port_pins_reduced,
	output logic [`SSP_SER_W-1:0] serial_port_pins_pull_en,
	output logic [`SSP_SER_W-1:0] serial_port_pins_pull_dn,
	input wire logic [`SSP_SPI_W-1:0] spi_port_pins_in,
	output logic [`SSP_SPI_W-1:0] spi_port_pins_out,
	output logic [`SSP_SPI_W-1:0] spi_port_pins_oe
);
	ssp_pkg::ssp_bus_state_t bus_state_q;

	logic [`SSP_SER_W-1:0] ser_data_q;
	logic [`SSP_SER_W-1:0] ser_dir_q;
	logic [`SSP_SER_W-1:0] ser_rdr_q;
	logic [`SSP_SER_W-1:0] ser_pe_q;
	logic [`SSP_SER_W-1:0] ser_ps_q;
	logic [`SSP_SER_W-1:0] ser_od_q;
	logic [`SSP_SPI_W-1:0] spi_data_q;
	logic [`SSP_SPI_W-1:0] spi_dir_q;

	logic [`SSP_SER_W-1:0] ser_pin_sync;
	logic [`SSP_SPI_W-1:0] spi_pin_sync;
	logic [`SSP_SER_W-1:0] ser_dir_eff;
	logic [`SSP_SPI_W-1:0] spi_dir_eff;

	logic [`SSP_SER_W-1:0] ser_ovr_en;
	logic [`SSP_SER_W-1:0] ser_ovr_dir;
	logic [`SSP_SER_W-1:0] ser_ovr_val;
	logic [`SSP_SPI_W-1:0] spi_ovr_en;
	logic [`SSP_SPI_W-1:0] spi_ovr_dir;
	logic [`SSP_SPI_W-1:0] spi_ovr_val;

	logic [`SSP_IDX_W-1:0] idx;
	logic setup;
	logic wr_done;
	logic hit;
	logic [`SSP_DATA_W-1:0] rd_d;
	logic [`SSP_SER_W-1:0] ser_data_rd;
	logic [`SSP_SPI_W-1:0] spi_data_rd;
	logic wr_ser_data;
	logic wr_ser_dir;
	logic wr_ser_rdr;
	logic wr_ser_pe;
	logic wr_ser_ps;
	logic wr_ser_od;
	logic wr_spi_data;
	logic wr_spi_dir;

	// Word index from the byte address
	assign idx = paddr[`SSP_ADDR_W-1:2];
	assign setup = psel & ~penable;
	assign wr_done = (bus_state_q == ssp_pkg::SSP_BUS_RESP) & psel & penable & pwrite;

	// One write strobe per register; input registers get none
	assign wr_ser_data = wr_done & (idx == `SSP_IDX_SER_DATA);
	assign wr_ser_dir = wr_done & (idx == `SSP_IDX_SER_DIR);
	assign wr_ser_rdr = wr_done & (idx == `SSP_IDX_SER_RDR);
	assign wr_ser_pe = wr_done & (idx == `SSP_IDX_SER_PE);
	assign wr_ser_ps = wr_done & (idx == `SSP_IDX_SER_PS);
	assign wr_ser_od = wr_done & (idx == `SSP_IDX_SER_OD);
	assign wr_spi_data = wr_done & (idx == `SSP_IDX_SPI_DATA);
	assign wr_spi_dir = wr_done & (idx == `SSP_IDX_SPI_DIR);

	// Pin sampling
	ssp_sync #(
		.W(`SSP_SER_W)
	) u_ser_sync (
		.clock(clock),
		.reset(reset),
		.clk_en(clk_en),
		.async_in(serial_port_pins_in),
		.sync_out(ser_pin_sync)
	);

	ssp_sync #(
		.W(`SSP_SPI_W)
	) u_spi_sync (
		.clock(clock),
		.reset(reset),
		.clk_en(clk_en),
		.async_in(spi_port_pins_in),
		.sync_out(spi_pin_sync)
	);

	// Serial channel overrides on the transmit and receive pins
	always_comb begin
		ser_ovr_en = '0;
		ser_ovr_dir = '0;
		ser_ovr_val = '0;
		ser_ovr_en[`SSP_TX_PIN] = sci_tx_en;
		ser_ovr_dir[`SSP_TX_PIN] = 1'b1;
		ser_ovr_val[`SSP_TX_PIN] = sci_txd;
		ser_ovr_en[`SSP_RX_PIN] = sci_rx_en;
		ser_ovr_dir[`SSP_RX_PIN] = 1'b0;
	end

	// SPI peripheral owns the upper pins while enabled
	always_comb begin
		spi_ovr_en = '0;
		spi_ovr_dir = '0;
		spi_ovr_val = '0;
		spi_ovr_en[`SSP_SPI_OVR_LO +: `SSP_SPI_OVR_W] = {`SSP_SPI_OVR_W{spi_en}};
		spi_ovr_dir[`SSP_SPI_OVR_LO +: `SSP_SPI_OVR_W] = spi_dir;
		spi_ovr_val[`SSP_SPI_OVR_LO +: `SSP_SPI_OVR_W] = spi_out;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `SSP_SER_W; gi++) begin : g_ser
			ssp_pin_ctrl u_pin (
				.clock(clock),
				.reset(reset),
				.clk_en(clk_en),
				.dir_bit(ser_dir_q[gi]),
				.ovr_en(ser_ovr_en[gi]),
				.ovr_dir(ser_ovr_dir[gi]),
				.ovr_val(ser_ovr_val[gi]),
				.data_bit(ser_data_q[gi]),
				.reduced_bit(ser_rdr_q[gi]),
				.pull_en_bit(ser_pe_q[gi]),
				.pull_dn_bit(ser_ps_q[gi]),
				.open_drain_bit(ser_od_q[gi]),
				.dir_eff(ser_dir_eff[gi]),
				.pin_out(serial_port_pins_out[gi]),
				.pin_oe(serial_port_pins_oe[gi]),
				.pin_reduced(serial_port_pins_reduced[gi]),
				.pin_pull_en(serial_port_pins_pull_en[gi]),
				.pin_pull_dn(serial_port_pins_pull_dn[gi])
			);
		end
		// SPI port has no drive, pull or open-drain settings; they are tied to 0
		for (gi = 0; gi < `SSP_SPI_W; gi++) begin : g_spi
			ssp_pin_ctrl u_pin (
				.clock(clock),
				.reset(reset),
				.clk_en(clk_en),
				.dir_bit(spi_dir_q[gi]),
				.ovr_en(spi_ovr_en[gi]),
				.ovr_dir(spi_ovr_dir[gi]),
				.ovr_val(spi_ovr_val[gi]),
				.data_bit(spi_data_q[gi]),
				.reduced_bit(1'b0),
				.pull_en_bit(1'b0),
				.pull_dn_bit(1'b0),
				.open_drain_bit(1'b0),
				.dir_eff(spi_dir_eff[gi]),
				.pin_out(spi_port_pins_out[gi]),
				.pin_oe(spi_port_pins_oe[gi]),
				.pin_reduced(),
				.pin_pull_en(),
				.pin_pull_dn()
			);
		end
	endgenerate

	// Latch for driven pins, sampled level otherwise
	assign ser_data_rd = (ser_dir_eff & ser_data_q) | (~ser_dir_eff & ser_pin_sync);
	assign spi_data_rd = (spi_dir_eff & spi_data_q) | (~spi_dir_eff & spi_pin_sync);

	// Read mux and address decode
	always_comb begin
		rd_d = '0;
		hit = 1'b1;
		case (idx)
			`SSP_IDX_SER_DATA: rd_d[`SSP_SER_W-1:0] = ser_data_rd;
			`SSP_IDX_SER_IN: rd_d[`SSP_SER_W-1:0] = ser_pin_sync;
			`SSP_IDX_SER_DIR: rd_d[`SSP_SER_W-1:0] = ser_dir_q;
			`SSP_IDX_SER_RDR: rd_d[`SSP_SER_W-1:0] = ser_rdr_q;
			`SSP_IDX_SER_PE: rd_d[`SSP_SER_W-1:0] = ser_pe_q;
			`SSP_IDX_SER_PS: rd_d[`SSP_SER_W-1:0] = ser_ps_q;
			`SSP_IDX_SER_OD: rd_d[`SSP_SER_W-1:0] = ser_od_q;
			`SSP_IDX_SPI_DATA: rd_d[`SSP_SPI_W-1:0] = spi_data_rd;
			`SSP_IDX_SPI_IN: rd_d[`SSP_SPI_W-1:0] = spi_pin_sync;
			`SSP_IDX_SPI_DIR: rd_d[`SSP_SPI_W-1:0] = spi_dir_q;
			default: hit = 1'b0;
		endcase
	end

	// APB handshake: answer prepared in setup, completed in access
	always_ff @(posedge clock) begin
		if (reset) begin
			bus_state_q <= ssp_pkg::SSP_BUS_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (clk_en) begin
			case (bus_state_q)
				ssp_pkg::SSP_BUS_IDLE: begin
					if (setup) begin
						bus_state_q <= ssp_pkg::SSP_BUS_RESP;
						pready <= 1'b1;
						pslverr <= ~hit;
						prdata <= pwrite ? '0 : rd_d;
					end
				end
				ssp_pkg::SSP_BUS_RESP: begin
					if (psel & penable) begin
						bus_state_q <= ssp_pkg::SSP_BUS_IDLE;
						pready <= 1'b0;
						pslverr <= 1'b0;
					end
				end
				default: begin
					bus_state_q <= ssp_pkg::SSP_BUS_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	// Serial port configuration registers
	always_ff @(posedge clock) begin
		if (reset) begin
			ser_dir_q <= `SSP_RST_SER_DIR;
		end else if (clk_en && wr_ser_dir) begin
			ser_dir_q <= pwdata[`SSP_SER_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ser_rdr_q <= `SSP_RST_SER_RDR;
		end else if (clk_en && wr_ser_rdr) begin
			ser_rdr_q <= pwdata[`SSP_SER_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ser_pe_q <= `SSP_RST_SER_PE;
		end else if (clk_en && wr_ser_pe) begin
			ser_pe_q <= pwdata[`SSP_SER_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ser_ps_q <= `SSP_RST_SER_PS;
		end else if (clk_en && wr_ser_ps) begin
			ser_ps_q <= pwdata[`SSP_SER_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ser_od_q <= `SSP_RST_SER_OD;
		end else if (clk_en && wr_ser_od) begin
			ser_od_q <= pwdata[`SSP_SER_W-1:0];
		end
	end

	// Data latches and SPI direction register; input registers take no writes
	always_ff @(posedge clock) begin
		if (reset) begin
			ser_data_q <= `SSP_RST_SER_DATA;
		end else if (clk_en && wr_ser_data) begin
			ser_data_q <= pwdata[`SSP_SER_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			spi_data_q <= `SSP_RST_SPI_DATA;
		end else if (clk_en && wr_spi_data) begin
			spi_data_q <= pwdata[`SSP_SPI_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			spi_dir_q <= `SSP_RST_SPI_DIR;
		end else if (clk_en && wr_spi_dir) begin
			spi_dir_q <= pwdata[`SSP_SPI_W-1:0];
		end
	end
endmodule

/* File: shared/ssp_cfg.svh */
// Constants for the serial-side port I/O control block
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_SER_W 4
`define SSP_SPI_W 6
`define SSP_SPI_OVR_W 4
`define SSP_SPI_OVR_LO 2
`define SSP_ADDR_W 8
`define SSP_DATA_W 32
`define SSP_IDX_W 6
`define SSP_TX_PIN 1
`define SSP_RX_PIN 0
`define SSP_IDX_SER_DATA 6'h08
`define SSP_IDX_SER_IN 6'h09
`define SSP_IDX_SER_DIR 6'h0A
`define SSP_IDX_SER_RDR 6'h0B
`define SSP_IDX_SER_PE 6'h0C
`define SSP_IDX_SER_PS 6'h0D
`define SSP_IDX_SER_OD 6'h0E
`define SSP_IDX_SPI_DATA 6'h10
`define SSP_IDX_SPI_IN 6'h11
`define SSP_IDX_SPI_DIR 6'h12
`define SSP_RST_SER_DATA 4'h0
`define SSP_RST_SER_DIR 4'h0
`define SSP_RST_SER_RDR 4'h0
`define SSP_RST_SER_PE 4'hF
`define SSP_RST_SER_PS 4'h0
`define SSP_RST_SER_OD 4'h0
`define SSP_RST_SPI_DATA 6'h00
`define SSP_RST_SPI_DIR 6'h00
`define SSP_RST_PULL_EN 1'h1
`endif

/* File: shared/ssp_pkg.sv */
// Types for the serial-side port I/O control block
package ssp_pkg;
	typedef enum logic [0:0] {
		SSP_BUS_IDLE = 1'b0,
		SSP_BUS_RESP = 1'b1
	} ssp_bus_state_t;
endpackage

/* File: hw/ssp_sync.sv */
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module ssp_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			meta_q <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

/* File: hw/ssp_pin_ctrl.sv */
// Per-pin direction, drive, pull and open-drain control
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_pin_ctrl (
	input wire logic clock,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic dir_bit,
	input wire logic ovr_en,
	input wire logic ovr_dir,
	input wire logic ovr_val,
	input wire logic data_bit,
	input wire logic reduced_bit,
	input wire logic pull_en_bit,
	input wire logic pull_dn_bit,
	input wire logic open_drain_bit,
	output logic dir_eff,
	output logic pin_out,
	output logic pin_oe,
	output logic pin_reduced,
	output logic pin_pull_en,
	output logic pin_pull_dn
);
	logic val;
	logic od_out;

	// Peripheral owns the pin while its channel is enabled
	assign dir_eff = ovr_en ? ovr_dir : dir_bit;
	assign val = ovr_en ? ovr_val : data_bit;
	assign od_out = dir_eff & open_drain_bit;

	always_ff @(posedge clock) begin
		if (reset) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			pin_reduced <= 1'b0;
			pin_pull_en <= `SSP_RST_PULL_EN;
			pin_pull_dn <= 1'b0;
		end else if (clk_en) begin
			pin_out <= val;
			// Open drain leaves a high undriven
			pin_oe <= dir_eff & ~(open_drain_bit & val);
			pin_reduced <= dir_eff & reduced_bit;
			// Pull-down only on inputs, pull-up on inputs and open drain
			pin_pull_en <= pull_en_bit & (~dir_eff | (od_out & ~pull_dn_bit));
			pin_pull_dn <= pull_dn_bit & ~dir_eff;
		end
	end
endmodule

/* File: dv/ssp_pin_world.sv */
// Pin-side model: outside drivers, pull devices and floating lines
`timescale 1ns/1ps
module ssp_pin_world #(
	parameter int W = 4
) (
	input wire logic clock,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] pull_en,
	input wire logic [W-1:0] pull_dn,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] level
);
	// Undriven, unpulled lines wander every cycle
	logic [W-1:0] float_q = '0;
	always_ff @(posedge clock) begin
		float_q <= ~float_q;
	end
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (oe[i]) begin
				level[i] = out[i];
			end else if (ext_en[i]) begin
				level[i] = ext_val[i];
			end else if (pull_en[i]) begin
				level[i] = ~pull_dn[i];
			end else begin
				level[i] = float_q[i];
			end
		end
	end
endmodule

/* File: dv/ssp_top_chk.sv */
// Port-level checker for the serial-side port block
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_top_chk (
	input wire logic clock,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SSP_ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sci_tx_en,
	input wire logic sci_rx_en,
	input wire logic sci_txd,
	input wire logic spi_en,
	input wire logic [`SSP_SPI_OVR_W-1:0] spi_dir,
	input wire logic [`SSP_SER_W-1:0] serial_port_pins_out,
	input wire logic [`SSP_SER_W-1:0] serial_port_pins_oe,
	input wire logic [`SSP_SER_W-1:0] serial_port_pins_pull_en,
	input wire logic [`SSP_SER_W-1:0] serial_port_pins_pull_dn,
	input wire logic [`SSP_SPI_W-1:0] spi_port_pins_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	AST_RESET_PULLS: assert property (
		$past(reset) |-> serial_port_pins_pull_en == 4'hF && serial_port_pins_pull_dn == 4'h0
		&& serial_port_pins_oe == 4'h0) else $error("pins wrong after reset");
	AST_TX_FORCE: assert property (
		clk_en && sci_tx_en |=> serial_port_pins_out[1] == $past(sci_txd))
		else $error("transmit pin not following transmitter");
	AST_RX_FORCE: assert property (
		clk_en && sci_rx_en |=> !serial_port_pins_oe[0]) else $error("receive pin driven");
	AST_SPI_OWNS: assert property (
		clk_en && spi_en |=> spi_port_pins_oe[5:2] == $past(spi_dir))
		else $error("spi pin direction not from spi");
	AST_NO_PULLDN_OUT: assert property (
		(serial_port_pins_pull_dn & serial_port_pins_oe) == 4'h0) else $error("pull-down on output");
	AST_NO_PULL_PP: assert property (
		(serial_port_pins_oe & serial_port_pins_out & serial_port_pins_pull_en) == 4'h0)
		else $error("pull on push-pull output");
	AST_READY_NEXT: assert property (
		clk_en && psel && !penable |=> pready) else $error("no ready in access cycle");
	AST_READY_ONE: assert property (
		pready |=> !pready) else $error("ready held two cycles");
	AST_IN_WRITE_OK: assert property (
		pready && pwrite && paddr[7:2] == `SSP_IDX_SER_IN |-> !pslverr)
		else $error("input register write flagged");
	AST_UNMAPPED_ERR: assert property (
		pready && paddr[7:2] == 6'h3F |-> pslverr) else $error("unmapped access not flagged");
endmodule
bind ssp_top ssp_top_chk i_ssp_top_chk (.clock, .reset, .clk_en, .psel, .penable, .pwrite,
	.paddr, .pready, .pslverr, .sci_tx_en, .sci_rx_en, .sci_txd, .spi_en, .spi_dir,
	.serial_port_pins_out, .serial_port_pins_oe, .serial_port_pins_pull_en,
	.serial_port_pins_pull_dn, .spi_port_pins_oe);

/* File: dv/testbench.sv */
// Self-checking bench for the serial-side port block
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module testbench;
	logic clock = 1'h0;
	logic reset = 1'h1;
	logic clk_en = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic sci_tx_en = 1'h0;
	logic sci_rx_en = 1'h0;
	logic sci_txd = 1'h0;
	logic spi_en = 1'h0;
	logic [3:0] spi_dir = 4'h0;
	logic [3:0] spi_out = 4'h0;
	logic [3:0] serial_port_pins_in, serial_port_pins_out, serial_port_pins_oe;
	logic [3:0] serial_port_pins_reduced, serial_port_pins_pull_en, serial_port_pins_pull_dn;
	logic [5:0] spi_port_pins_in, spi_port_pins_out, spi_port_pins_oe;
	logic [3:0] ser_ext_en = 4'hF;
	logic [3:0] ser_ext_val = 4'hA;
	logic [5:0] spi_ext_en = 6'h00;
	logic [5:0] spi_ext_val = 6'h00;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	ssp_top i_ssp_top (.*);
	ssp_pin_world #(.W(4)) i_ser_world (.clock(clock), .out(serial_port_pins_out),
		.oe(serial_port_pins_oe), .pull_en(serial_port_pins_pull_en),
		.pull_dn(serial_port_pins_pull_dn), .ext_en(ser_ext_en), .ext_val(ser_ext_val),
		.level(serial_port_pins_in));
	ssp_pin_world #(.W(6)) i_spi_world (.clock(clock), .out(spi_port_pins_out),
		.oe(spi_port_pins_oe), .pull_en(6'h00), .pull_dn(6'h00), .ext_en(spi_ext_en),
		.ext_val(spi_ext_val), .level(spi_port_pins_in));
	initial begin
		forever #25 clock = ~clock;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
		logic [31:0] rd;
		logic err;
		apb(1'h1, idx, wd, rd, err);
	endtask
	task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'h0, idx, 32'h0, rd, err);
		chk(rd, exp);
	endtask
	task automatic settle();
		repeat (4) @(posedge clock);
		#1;
	endtask
	task automatic t_reset();
		rdchk(`SSP_IDX_SER_DIR, 32'h0);
		rdchk(`SSP_IDX_SER_RDR, 32'h0);
		rdchk(`SSP_IDX_SER_OD, 32'h0);
		rdchk(`SSP_IDX_SER_PE, 32'hF);
		rdchk(`SSP_IDX_SER_PS, 32'h0);
		chk(32'(serial_port_pins_pull_en), 32'hF);
		$display("t_reset done");
	endtask
	task automatic t_dir();
		ser_ext_en <= 4'h0;
		wr(`SSP_IDX_SER_DATA, 32'h5);
		wr(`SSP_IDX_SER_DIR, 32'hF);
		wr(`SSP_IDX_SER_RDR, 32'hF);
		settle();
		chk(32'(serial_port_pins_oe), 32'hF);
		chk(32'(serial_port_pins_out), 32'h5);
		chk(32'(serial_port_pins_pull_en), 32'h0);
		chk(32'(serial_port_pins_reduced), 32'hF);
		wr(`SSP_IDX_SER_OD, 32'hF);
		settle();
		chk(32'(serial_port_pins_oe), 32'hA);
		chk(32'(serial_port_pins_pull_en), 32'hF);
		rdchk(`SSP_IDX_SER_DATA, 32'h5);
		// Released open-drain highs come back through the pull-ups
		rdchk(`SSP_IDX_SER_IN, 32'h5);
		wr(`SSP_IDX_SER_PS, 32'hF);
		settle();
		chk(32'(serial_port_pins_pull_dn), 32'h0);
		chk(32'(serial_port_pins_pull_en), 32'h0);
		ser_ext_en <= 4'hF;
		wr(`SSP_IDX_SER_DIR, 32'h0);
		repeat (2) @(posedge clock);
		rdchk(`SSP_IDX_SER_DATA, 32'hA);
		chk(32'(serial_port_pins_reduced), 32'h0);
		chk(32'(serial_port_pins_pull_dn), 32'hF);
		wr(`SSP_IDX_SER_OD, 32'h0);
		wr(`SSP_IDX_SER_PS, 32'h0);
		$display("t_dir done");
	endtask
	task automatic t_sci();
		@(posedge clock);
		sci_tx_en <= 1'h1;
		sci_rx_en <= 1'h1;
		sci_txd <= 1'h1;
		settle();
		chk(32'(serial_port_pins_oe), 32'h2);
		wr(`SSP_IDX_SER_DIR, 32'hF);
		settle();
		chk(32'(serial_port_pins_oe), 32'hE);
		@(posedge clock);
		sci_tx_en <= 1'h0;
		sci_rx_en <= 1'h0;
		settle();
		chk(32'(serial_port_pins_oe), 32'hF);
		wr(`SSP_IDX_SER_DIR, 32'h0);
		$display("t_sci done");
	endtask
	task automatic t_freeze();
		@(posedge clock);
		clk_en <= 1'h0;
		sci_tx_en <= 1'h1;
		settle();
		chk(32'(serial_port_pins_oe), 32'h0);
		@(posedge clock);
		clk_en <= 1'h1;
		settle();
		chk(32'(serial_port_pins_oe), 32'h2);
		@(posedge clock);
		sci_tx_en <= 1'h0;
		$display("t_freeze done");
	endtask
	task automatic t_spi();
		logic [31:0] rd;
		logic err;
		wr(`SSP_IDX_SPI_DATA, 32'h2A);
		wr(`SSP_IDX_SPI_DIR, 32'h3F);
		wr(`SSP_IDX_SER_IN, 32'h3);
		wr(`SSP_IDX_SPI_IN, 32'h15);
		settle();
		chk(32'(serial_port_pins_out), 32'h5);
		rdchk(`SSP_IDX_SPI_DATA, 32'h2A);
		rdchk(`SSP_IDX_SPI_IN, 32'h2A);
		apb(1'h0, 6'h3F, 32'h0, rd, err);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		@(posedge clock);
		spi_en <= 1'h1;
		spi_dir <= 4'h5;
		spi_out <= 4'h4;
		settle();
		chk(32'(spi_port_pins_oe[5:2]), 32'h5);
		chk(32'(spi_port_pins_out[5:2] & 4'h5), 32'h4);
		// Pins 5 and 4 become inputs driven from outside
		@(posedge clock);
		spi_en <= 1'h0;
		spi_ext_en <= 6'h3F;
		spi_ext_val <= 6'h15;
		wr(`SSP_IDX_SPI_DIR, 32'h0F);
		settle();
		rdchk(`SSP_IDX_SPI_DATA, 32'h1A);
		$display("t_spi done");
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'h0;
		t_reset();
		t_dir();
		t_sci();
		t_freeze();
		t_spi();
		report_and_stop();
	end
endmodule
